// ---- tb/sicl_video_src.sv ----
// Video source model: line, frame, green sync and clamp lines
`timescale 1ns/1ps
module sicl_video_src #(
   parameter int LP = 40, // Line period in cycles
   parameter int SW = 8, // Line sync width
   parameter int FL = 6, // Lines per frame
   parameter int FW = 2, // Frame sync width in lines
   parameter int CW = 5 // Clamp pulse width
) (
   input wire logic clk_sys, // Source clock
   input wire logic rstn, // Reset, active low
   input wire logic line_act_high, // Line sync sense
   output logic line_sync, // Line sync pin
   output logic frame_sync, // Frame sync pin, active low
   output logic green_sync, // Slicer comparator, low at sync tip
   output logic ext_clamp // Clamp pin, active high
);
   int pix;
   int ln;
   int pos;
   int off;
   logic odd;
   // Frame position; odd frames start their pulse half a line after even frames
   always_comb begin
      pos = ln * LP + pix;
      off = odd ? LP / 2 + 2 : 2;
   end
   // Pixel, line and frame parity counters
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pix <= 0;
         ln <= 0;
         odd <= 1'b0;
      end else if (pix == LP - 1) begin
         pix <= 0;
         ln <= (ln == FL - 1) ? 0 : ln + 1;
         if (ln == FL - 1) begin
            odd <= !odd;
         end
      end else begin
         pix <= pix + 1;
      end
   end
   // Pin levels
   always_ff @(posedge clk_sys) begin
      line_sync <= ((pix < SW) == line_act_high);
      frame_sync <= !(pos >= off && pos < off + FW * LP);
      green_sync <= !(pix < SW);
      ext_clamp <= (pix >= SW + 2) && (pix < SW + 2 + CW);
   end
endmodule : sicl_video_src

// ---- tb/testbench.sv ----
// Self-checking bench for the sync and clamp front end
`timescale 1ns/1ps
module testbench;
   import sicl_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic src_high = 1'b0;
   logic la, lb, fa, fb, ga, gb, cl;
   logic [THR_W-1:0] slice_threshold;
   logic sliced, pll_lock_pulse, clamp_out, coast_out, field_odd;
   logic [5:0] mon;
   logic [31:0] rd;
   logic err;
   logic f1;
   int cnt;
   int n_mismatch = 0;
   int n_compared = 0;
   // Watched signals by index
   assign mon = {sliced, lb, la, coast_out, clamp_out, pll_lock_pulse};
   always #20 clk_sys = ~clk_sys;
   sicl_video_src #(.LP(40), .SW(8)) u_src_a (.clk_sys(clk_sys), .rstn(rstn), .line_act_high(src_high),
      .line_sync(la), .frame_sync(fa), .green_sync(ga), .ext_clamp(cl));
   sicl_video_src #(.LP(50), .SW(10)) u_src_b (.clk_sys(clk_sys), .rstn(rstn), .line_act_high(src_high),
      .line_sync(lb), .frame_sync(fb), .green_sync(gb), .ext_clamp());
   sicl_top #(.FRAME_SEP(8)) u_sicl_top (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_sync_in_a(la), .line_sync_in_b(lb), .frame_sync_in_a(fa), .frame_sync_in_b(fb),
      .green_embedded_sync_in_a(ga), .green_embedded_sync_in_b(gb), .ext_clamp_in(cl),
      .slice_threshold(slice_threshold), .sliced_composite_sync_out(sliced), .pll_lock_pulse(pll_lock_pulse),
      .clamp_out(clamp_out), .coast_out(coast_out), .field_odd(field_odd));
   // Verdict and end of run
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // Compare seen against expected
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One APB transfer; waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         check("pready timeout", 0, 1);
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Wait until watched signal i equals v; cnt holds the edges waited
   task waitv(input int i, input logic v);
      cnt = 0;
      while (mon[i] !== v) begin
         @(posedge clk_sys);
         cnt++;
         if (cnt > 3000) begin
            check("wait timeout", 0, 1);
            conclude();
         end
      end
   endtask : waitv
   // Length of the next run of level v on signal i
   task width(input int i, input logic v);
      waitv(i, !v);
      waitv(i, v);
      waitv(i, !v);
   endtask : width
   // Reset values, threshold code, unmapped address
   task t_regs;
      apb(0, ADDR_SYNC_CFG, 0); check("sync_cfg", rd, 0);
      apb(0, ADDR_FRAME_CFG, 0); check("frame_cfg", rd, 0);
      apb(0, ADDR_CLAMP_CFG, 0); check("clamp_cfg", rd, 0);
      apb(0, ADDR_CLAMP_TIME, 0); check("clamp_time", rd, 32'h1408);
      check("thr_port", 32'(slice_threshold), 32'h10);
      apb(1, ADDR_SLICE_THR, 32'h1F);
      apb(0, ADDR_SLICE_THR, 0); check("thr_reg", rd, 32'h1F);
      check("thr_port", 32'(slice_threshold), 32'h1F);
      apb(1, 8'h04, 32'h5); check("unmapped_err", 32'(err), 1);
   endtask : t_regs
   // Lock edge under manual and automatic line sense
   task t_line;
      logic [7:0] cfg [5] = '{8'h20, 8'h30, 8'h00, 8'h00, 8'h30};
      logic hi [5] = '{0, 0, 0, 1, 1};
      logic rise [5] = '{0, 1, 0, 1, 1};
      for (int j = 0; j < 5; j++) begin
         src_high <= hi[j];
         apb(1, ADDR_SYNC_CFG, 32'(cfg[j]));
         repeat (120) @(posedge clk_sys);
         waitv(3, !rise[j]);
         waitv(3, rise[j]);
         waitv(0, 1);
         check("lock_delay_ok", 32'(cnt >= 2 && cnt <= 8), 1);
      end
      src_high <= 1'b0;
      apb(1, ADDR_SYNC_CFG, 32'h20);
   endtask : t_line
   // Internal clamp delay and duration from trailing edge; pin ignored
   task t_clamp_int;
      logic [31:0] tm [2] = '{32'h0604, 32'h0300};
      int dl [2] = '{4, 0};
      for (int j = 0; j < 2; j++) begin
         apb(1, ADDR_CLAMP_TIME, tm[j]);
         repeat (80) @(posedge clk_sys);
         waitv(3, 0);
         waitv(3, 1);
         waitv(1, 1);
         check("clamp_delay_ok", 32'(cnt >= dl[j] + 2 && cnt <= dl[j] + 8), 1);
         waitv(1, 0);
         check("clamp_width", cnt, tm[j] >> 8);
      end
   endtask : t_clamp_int
   // External clamp with auto and manual sense
   task t_clamp_ext;
      logic [7:0] cfg [3] = '{8'h10, 8'hD0, 8'h90};
      int w [3] = '{5, 5, 35};
      for (int j = 0; j < 3; j++) begin
         apb(1, ADDR_CLAMP_CFG, 32'(cfg[j]));
         repeat (120) @(posedge clk_sys);
         width(1, 1); check("ext_clamp_width", cnt, w[j]);
      end
      apb(1, ADDR_CLAMP_CFG, 0);
   endtask : t_clamp_ext
   // Channel select: line period and slicer pulse follow the chosen set
   task t_chan;
      for (int s = 1; s >= 0; s--) begin
         apb(1, ADDR_CTRL, 32'(s));
         repeat (150) @(posedge clk_sys);
         width(0, 0); check("lock_gap", cnt, s ? 49 : 39);
         apb(0, ADDR_STATUS, 0);
         check("line_len", 32'(rd[31:16]), s ? 49 : 39);
         width(5, 0); check("sliced_low", cnt, s ? 10 : 8);
      end
   endtask : t_chan
   // Coast length under frame sense settings, then field alternation
   task t_frame;
      logic [7:0] cfg [3] = '{8'h00, 8'h30, 8'h20};
      // Inactive run alternates by a whole line with the half-line odd frame offset
      int wa [3] = '{80, 140, 80};
      int wb [3] = '{80, 180, 80};
      for (int j = 0; j < 3; j++) begin
         apb(1, ADDR_FRAME_CFG, 32'(cfg[j]));
         repeat (500) @(posedge clk_sys);
         width(2, 1); check("coast_width", 32'(cnt == wa[j] || cnt == wb[j]), 1);
      end
      waitv(2, 0);
      waitv(2, 1);
      repeat (4) @(posedge clk_sys);
      f1 = field_odd;
      waitv(2, 0);
      waitv(2, 1);
      repeat (4) @(posedge clk_sys);
      check("field_toggles", 32'(f1 !== field_odd), 1);
   endtask : t_frame
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_line();
      t_clamp_int();
      t_clamp_ext();
      t_chan();
      t_frame();
      conclude();
   end
endmodule : testbench

// ---- verilog/sicl_pkg.sv ----
// Constants shared by the sync and clamp front end
package sicl_pkg;
   // Register indices and byte addresses
   localparam logic [7:0] IDX_SYNC_CFG = 8'h12;
   localparam logic [7:0] IDX_FRAME_CFG = 8'h14;
   localparam logic [7:0] IDX_CLAMP_CFG = 8'h18;
   localparam logic [7:0] IDX_CTRL = 8'h20;
   localparam logic [7:0] IDX_SLICE_THR = 8'h21;
   localparam logic [7:0] IDX_CLAMP_TIME = 8'h22;
   localparam logic [7:0] IDX_STATUS = 8'h23;
   localparam logic [7:0] ADDR_SYNC_CFG = 8'(IDX_SYNC_CFG << 2);
   localparam logic [7:0] ADDR_FRAME_CFG = 8'(IDX_FRAME_CFG << 2);
   localparam logic [7:0] ADDR_CLAMP_CFG = 8'(IDX_CLAMP_CFG << 2);
   localparam logic [7:0] ADDR_CTRL = 8'(IDX_CTRL << 2);
   localparam logic [7:0] ADDR_SLICE_THR = 8'(IDX_SLICE_THR << 2);
   localparam logic [7:0] ADDR_CLAMP_TIME = 8'(IDX_CLAMP_TIME << 2);
   localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS << 2);
   // Field positions
   localparam int POL_MANUAL_BIT = 5;
   localparam int POL_VALUE_BIT = 4;
   localparam int CLAMP_EXT_BIT = 4;
   localparam int CLAMP_MANUAL_BIT = 7;
   localparam int CLAMP_VALUE_BIT = 6;
   localparam int CTRL_CHSEL_BIT = 0;
   localparam int CTRL_COMPOSITE_BIT = 1;
   localparam int THR_W = 5;
   localparam int CNT_W = 8;
   localparam int LINE_W = 16;
   // Values after reset
   localparam logic [7:0] SYNC_CFG_RST = 8'h00;
   localparam logic [7:0] FRAME_CFG_RST = 8'h00;
   localparam logic [7:0] CLAMP_CFG_RST = 8'h00;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [THR_W-1:0] SLICE_THR_RST = 5'h10;
   localparam logic [CNT_W-1:0] CLAMP_DELAY_RST = 8'h08;
   localparam logic [CNT_W-1:0] CLAMP_DUR_RST = 8'h14;
   // Slicer step and timing
   localparam int SLICE_STEP_MV = 8;
   localparam int CLK_PERIOD_NS = 40;
   localparam int FRAME_SEP_NS = 10000;
   localparam int FRAME_SEP_CYCLES = (FRAME_SEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Internal clamp sequencer
   typedef enum logic [1:0] {
      SICL_IDLE = 2'b00,
      SICL_DELAY = 2'b01,
      SICL_HOLD = 2'b10
   } sicl_clamp_st_t;
endpackage : sicl_pkg

// ---- verilog/sicl_pol_if.sv ----
// Interface between a synced input and its sense detector
`timescale 1ns/1ps
interface sicl_pol_if;
   logic level;
   logic active_high;
   modport det (input level, output active_high);
   modport src (output level, input active_high);
endinterface : sicl_pol_if

// ---- verilog/sicl_poldet.sv ----
// Automatic sense detector for one synced sync or clamp input
`timescale 1ns/1ps
module sicl_poldet #(
   parameter int CW = 16 // Width of level counters
) (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Synchronous reset, active low
   sicl_pol_if.det p // Level in, decided sense out
);
   logic prev_reg;
   logic [CW-1:0] high_reg;
   logic [CW-1:0] low_reg;
   logic act_reg;
   wire rise = p.level & ~prev_reg;

   // Previous level for edge finding
   always_ff @(posedge clk_sys) begin
      if (!rstn) prev_reg <= 1'b0;
      else prev_reg <= p.level;
   end

   // Saturating count of high and low cycles over one period
   always_ff @(posedge clk_sys) begin
      if (!rstn || rise) begin
         high_reg <= '0;
         low_reg <= '0;
      end else if (p.level) begin
         if (~&high_reg) high_reg <= high_reg + 1'b1;
      end else begin
         if (~&low_reg) low_reg <= low_reg + 1'b1;
      end
   end

   // Minority level of the period is taken as active
   always_ff @(posedge clk_sys) begin
      if (!rstn) act_reg <= 1'b0;
      else if (rise) act_reg <= (high_reg < low_reg);
   end
   assign p.active_high = act_reg;

   property p_minority;
      @(posedge clk_sys) disable iff (!rstn)
      rise |=> (act_reg == ($past(high_reg) < $past(low_reg)));
   endproperty
   a_minority: assert property (p_minority) else $error("sense not taken from minority level");
endmodule : sicl_poldet

// ---- verilog/sicl_top.sv ----
// Sync input selection, sense handling, field, coast and clamp timing
`timescale 1ns/1ps
module sicl_top #(
   parameter int FRAME_SEP = sicl_pkg::FRAME_SEP_CYCLES // Composite pulse width taken as frame sync
) (
   input wire logic clk_sys, // System clock, 25 MHz
   input wire logic rstn, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic line_sync_in_a, // Line sync, channel a
   input wire logic line_sync_in_b, // Line sync, channel b
   input wire logic frame_sync_in_a, // Frame sync, channel a
   input wire logic frame_sync_in_b, // Frame sync, channel b
   input wire logic green_embedded_sync_in_a, // Slicer comparator, channel a
   input wire logic green_embedded_sync_in_b, // Slicer comparator, channel b
   input wire logic ext_clamp_in, // External clamp pin
   output logic [sicl_pkg::THR_W-1:0] slice_threshold, // Slicer threshold code
   output logic sliced_composite_sync_out, // Non-inverted composite sync
   output logic pll_lock_pulse, // Leading edge of line sync
   output logic clamp_out, // Clamp window
   output logic coast_out, // Internal coast interval
   output logic field_odd // Odd field flag
);
   import sicl_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // Configuration registers
   logic [7:0] sync_cfg_reg;
   logic [7:0] frame_cfg_reg;
   logic [7:0] clamp_cfg_reg;
   logic [1:0] ctrl_reg;
   logic [THR_W-1:0] thr_reg;
   logic [CNT_W-1:0] clamp_delay_reg;
   logic [CNT_W-1:0] clamp_dur_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   // Input synchronisers and selected set
   logic [6:0] sync1_reg;
   logic [6:0] sync2_reg;
   logic [2:0] raw_sel;
   logic [2:0] sense_eff;
   logic [2:0] act;
   logic [2:0] auto_sense;
   logic clamp_ext_en;
   logic sliced_reg;
   logic comp_frame_reg;
   logic [LINE_W-1:0] comp_width_reg;
   // Timing state
   logic h_act_d_reg;
   logic v_act_d_reg;
   logic pll_lock_reg;
   logic coast_reg;
   logic field_reg;
   logic clamp_reg;
   logic [LINE_W-1:0] line_pos_reg;
   logic [LINE_W-1:0] line_len_reg;
   sicl_clamp_st_t clamp_st_reg;
   logic [CNT_W-1:0] clamp_cnt_reg;
   logic int_active;
   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   wire h_lead = act[0] & ~h_act_d_reg;
   wire h_trail = ~act[0] & h_act_d_reg;
   wire v_lead = act[1] & ~v_act_d_reg;
   wire sel_b = ctrl_reg[CTRL_CHSEL_BIT];
   wire use_comp = ctrl_reg[CTRL_COMPOSITE_BIT];
   // APB write side
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sync_cfg_reg <= SYNC_CFG_RST;
         frame_cfg_reg <= FRAME_CFG_RST;
         clamp_cfg_reg <= CLAMP_CFG_RST;
         ctrl_reg <= CTRL_RST;
         thr_reg <= SLICE_THR_RST;
         clamp_delay_reg <= CLAMP_DELAY_RST;
         clamp_dur_reg <= CLAMP_DUR_RST;
      end else if (wr_en) begin
         if (paddr == ADDR_SYNC_CFG) begin
            sync_cfg_reg <= pwdata[7:0];
         end else if (paddr == ADDR_FRAME_CFG) begin
            frame_cfg_reg <= pwdata[7:0];
         end else if (paddr == ADDR_CLAMP_CFG) begin
            clamp_cfg_reg <= pwdata[7:0];
         end else if (paddr == ADDR_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end else if (paddr == ADDR_SLICE_THR) begin
            thr_reg <= pwdata[THR_W-1:0];
         end else if (paddr == ADDR_CLAMP_TIME) begin
            clamp_delay_reg <= pwdata[7:0];
            clamp_dur_reg <= pwdata[15:8];
         end
      end
   end
   // APB read data and error, prepared in the setup cycle
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         pslverr_reg <= 1'b0;
         if (paddr == ADDR_SYNC_CFG) begin
            prdata_reg <= {24'h0, sync_cfg_reg};
         end else if (paddr == ADDR_FRAME_CFG) begin
            prdata_reg <= {24'h0, frame_cfg_reg};
         end else if (paddr == ADDR_CLAMP_CFG) begin
            prdata_reg <= {24'h0, clamp_cfg_reg};
         end else if (paddr == ADDR_CTRL) begin
            prdata_reg <= {30'h0, ctrl_reg};
         end else if (paddr == ADDR_SLICE_THR) begin
            prdata_reg <= {27'h0, thr_reg};
         end else if (paddr == ADDR_CLAMP_TIME) begin
            prdata_reg <= {16'h0, clamp_dur_reg, clamp_delay_reg};
         end else if (paddr == ADDR_STATUS) begin
            prdata_reg <= {line_len_reg, 10'h0, clamp_reg, coast_reg, field_reg, sense_eff};
         end else begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b1;
         end
      end
   end
   // One wait-free access cycle after setup
   always_ff @(posedge clk_sys) begin
      if (!rstn) pready_reg <= 1'b0;
      else pready_reg <= setup;
   end
   // Two-flop synchronisers on every sync and clamp input pin
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sync1_reg <= 7'h0;
         sync2_reg <= 7'h0;
      end else begin
         sync1_reg <= {ext_clamp_in, green_embedded_sync_in_b, green_embedded_sync_in_a,
                       frame_sync_in_b, frame_sync_in_a, line_sync_in_b, line_sync_in_a};
         sync2_reg <= sync1_reg;
      end
   end
   // Selected slicer output, passed on non-inverted
   always_ff @(posedge clk_sys) begin
      if (!rstn) sliced_reg <= 1'b0;
      else sliced_reg <= sel_b ? sync2_reg[5] : sync2_reg[4];
   end

   // Composite separation: a long active pulse is frame sync
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         comp_width_reg <= '0;
         comp_frame_reg <= 1'b0;
      end else if (sliced_reg == sense_eff[0]) begin
         if (comp_width_reg != LINE_W'(FRAME_SEP)) comp_width_reg <= comp_width_reg + 1'b1;
         else comp_frame_reg <= 1'b1;
      end else begin
         comp_width_reg <= '0;
         comp_frame_reg <= 1'b0;
      end
   end

   // Source selection and sense detection per signal
   always_comb begin
      raw_sel[0] = use_comp ? (sliced_reg & ~comp_frame_reg) : (sel_b ? sync2_reg[1] : sync2_reg[0]);
      raw_sel[1] = use_comp ? ~comp_frame_reg : (sel_b ? sync2_reg[3] : sync2_reg[2]);
      raw_sel[2] = sync2_reg[6];
   end

   // Effective sense: manual bit wins over detected sense
   always_comb begin
      sense_eff[0] = sync_cfg_reg[POL_MANUAL_BIT] ? sync_cfg_reg[POL_VALUE_BIT] : auto_sense[0];
      sense_eff[1] = frame_cfg_reg[POL_MANUAL_BIT] ? frame_cfg_reg[POL_VALUE_BIT] : auto_sense[1];
      sense_eff[2] = clamp_cfg_reg[CLAMP_MANUAL_BIT] ? clamp_cfg_reg[CLAMP_VALUE_BIT] : auto_sense[2];
      if (use_comp) begin
         sense_eff[1] = 1'b0;
      end
   end

   sicl_pol_if pif[3] ();
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sense
         assign pif[gi].level = raw_sel[gi];
         assign auto_sense[gi] = pif[gi].active_high;
         assign act[gi] = sense_eff[gi] ? raw_sel[gi] : ~raw_sel[gi];
         sicl_poldet #(.CW(LINE_W)) u_det (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .p(pif[gi])
         );
      end
   endgenerate
   assign clamp_ext_en = clamp_cfg_reg[CLAMP_EXT_BIT];

   // Edge history and pixel clock lock pulse
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         h_act_d_reg <= 1'b1; // Active level seen while synchronisers are clear
         v_act_d_reg <= 1'b1; // Avoids a false edge just after reset
         pll_lock_reg <= 1'b0;
      end else begin
         h_act_d_reg <= act[0];
         v_act_d_reg <= act[1];
         pll_lock_reg <= h_lead;
      end
   end

   // Line position and length between leading edges
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         line_pos_reg <= '0;
         line_len_reg <= '0;
      end else if (h_lead) begin
         line_len_reg <= line_pos_reg;
         line_pos_reg <= '0;
      end else if (~&line_pos_reg) begin
         line_pos_reg <= line_pos_reg + 1'b1;
      end
   end

   // Field and coast from frame sync
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         field_reg <= 1'b0;
         coast_reg <= 1'b0;
      end else begin
         coast_reg <= act[1];
         if (v_lead) field_reg <= (line_pos_reg >= (line_len_reg >> 1));
      end
   end

   // Internal clamp: delay then hold from line sync trailing edge
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         clamp_st_reg <= SICL_IDLE;
         clamp_cnt_reg <= '0;
      end else if (h_trail) begin
         clamp_st_reg <= (clamp_delay_reg == '0) ? SICL_HOLD : SICL_DELAY;
         clamp_cnt_reg <= (clamp_delay_reg == '0) ? clamp_dur_reg : clamp_delay_reg;
      end else begin
         case (clamp_st_reg)
            SICL_DELAY: begin
               if (clamp_cnt_reg == 8'h01) begin
                  clamp_st_reg <= SICL_HOLD;
                  clamp_cnt_reg <= clamp_dur_reg;
               end else begin
                  clamp_cnt_reg <= clamp_cnt_reg - 1'b1;
               end
            end
            SICL_HOLD: begin
               if (clamp_cnt_reg <= 8'h01) clamp_st_reg <= SICL_IDLE;
               else clamp_cnt_reg <= clamp_cnt_reg - 1'b1;
            end
            default: begin
               clamp_st_reg <= SICL_IDLE;
            end
         endcase
      end
   end
   assign int_active = (clamp_st_reg == SICL_HOLD) && (clamp_cnt_reg != '0);

   // Clamp source choice; external pin only when enabled
   always_ff @(posedge clk_sys) begin
      if (!rstn) clamp_reg <= 1'b0;
      else clamp_reg <= clamp_ext_en ? act[2] : int_active;
   end

   // Outputs from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign slice_threshold = thr_reg;
   assign sliced_composite_sync_out = sliced_reg;
   assign pll_lock_pulse = pll_lock_reg;
   assign clamp_out = clamp_reg;
   assign coast_out = coast_reg;
   assign field_odd = field_reg;

   // Helper: measured hold length of internal clamp
   logic [CNT_W:0] hold_meas_reg;
   always_ff @(posedge clk_sys) begin
      if (!rstn || !int_active) hold_meas_reg <= '0;
      else hold_meas_reg <= hold_meas_reg + 1'b1;
   end
   // Normalised line sync going from inactive to active
   sequence s_lead_seen;
      !act[0] ##1 act[0];
   endsequence
   property p_lock_leading;
      pll_lock_reg |-> ($past(act[0]) && !$past(act[0], 2));
   endproperty
   a_lock_leading: assert property (p_lock_leading) else $error("lock pulse without leading edge");
   property p_lock_every;
      s_lead_seen |=> pll_lock_reg;
   endproperty
   a_lock_every: assert property (p_lock_every) else $error("leading edge without lock pulse");
   property p_lock_rising;
      (sense_eff[0] && $past(sense_eff[0]) && $rose(raw_sel[0]) && !use_comp && !$past(use_comp)) |=> pll_lock_reg;
   endproperty
   a_lock_rising: assert property (p_lock_rising) else $error("rising edge not active at polarity 1");
   property p_hsense_manual;
      sync_cfg_reg[POL_MANUAL_BIT] |-> (act[0] == (raw_sel[0] ~^ sync_cfg_reg[POL_VALUE_BIT]));
   endproperty
   a_hsense_manual: assert property (p_hsense_manual) else $error("manual line sense ignored");
   property p_vsense_manual;
      (frame_cfg_reg[POL_MANUAL_BIT] && !use_comp) |-> (act[1] == (raw_sel[1] ~^ frame_cfg_reg[POL_VALUE_BIT]));
   endproperty
   a_vsense_manual: assert property (p_vsense_manual) else $error("manual frame sense ignored");
   property p_field;
      v_lead |=> (field_reg == ($past(line_pos_reg) >= ($past(line_len_reg) >> 1)));
   endproperty
   a_field: assert property (p_field) else $error("field flag wrong at frame edge");
   property p_ext_ignored;
      (!clamp_ext_en && !int_active) |=> !clamp_reg;
   endproperty
   a_ext_ignored: assert property (p_ext_ignored) else $error("clamp active from ignored pin");
   property p_ext_follow;
      (clamp_ext_en && clamp_cfg_reg[CLAMP_MANUAL_BIT]) ##1 clamp_ext_en |->
         (clamp_reg == ($past(clamp_cfg_reg[CLAMP_VALUE_BIT]) ~^ $past(sync2_reg[6])));
   endproperty
   a_ext_follow: assert property (p_ext_follow) else $error("external clamp sense wrong");
   property p_delay_quiet;
      (h_trail && clamp_delay_reg != '0) |=> !int_active;
   endproperty
   a_delay_quiet: assert property (p_delay_quiet) else $error("clamp started before delay");
   property p_hold_len;
      ($fell(int_active) && !$past(h_trail)) |-> ($past(hold_meas_reg) + 1'b1 == {1'b0, $past(clamp_dur_reg)});
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("clamp hold length wrong");
   property p_slice_sel;
      ##1 sliced_reg == ($past(sel_b) ? $past(sync2_reg[5]) : $past(sync2_reg[4]));
   endproperty
   a_slice_sel: assert property (p_slice_sel) else $error("slicer output not from selected set");
endmodule : sicl_top
